/* smx_mode_ext.v */
// Serial port mode extensions: flow control, DMA, smart card, IrDA, FIFO

`include "smx_regs.vh"

// Synchronous FIFO with valid/ready on both sides
// A full buffer holds in_ready low; the writer must keep its word valid
module smx_fifo #(
    parameter W = `SMX_DATA_W,
    parameter D = `SMX_FIFO_DEPTH,
    parameter AW = `SMX_FIFO_AW
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [W-1:0] out_data,
    output wire out_valid,
    input wire out_ready,
    output reg [AW:0] count
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    wire push;
    wire pop;

    assign in_ready = (count != D[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage write
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}}
                          : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}}
                          : rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // smx_fifo

// Mode extension logic around the frame engine
module smx_mode_ext (
    input wire mclk,
    input wire arst_n,
    input wire [`SMX_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire baud_tick,
    input wire os_tick,
    input wire tx_bit,
    input wire tx_active,
    input wire tx_buf_empty,
    input wire tx_char_req,
    output wire tx_char_go,
    input wire tx_char_end,
    output reg tx_complete_set,
    output reg tx_dma_req,
    output wire rx_bit,
    input wire [`SMX_DATA_W-1:0] rx_char,
    input wire rx_char_valid,
    output wire rx_char_ready,
    input wire rx_parity_err,
    input wire framing_error_flag,
    input wire overrun_flag,
    input wire noise_flag,
    input wire cts_change_flag,
    output reg rx_dma_req,
    input wire rx_dma_ack,
    output reg flow_irq,
    output reg err_irq,
    input wire cts_n,
    output reg rts_n,
    input wire txd_i,
    output reg txd_o,
    output reg txd_oe,
    input wire rxd_i,
    input wire ir_in,
    output reg ir_out,
    output reg card_clk
);
    reg [`SMX_MODE_W-1:0] mode_ctl;
    reg [`SMX_GP_W-1:0] guard_pre;
    reg [7:0] lp_cnt;
    reg lp_tick;
    reg [4:0] card_cnt;
    reg [1:0] ir_width;
    reg ir_zero_seen;
    reg [1:0] nack_cnt;
    reg [7:0] guard_cnt;
    reg guard_busy;
    reg [`SMX_DATA_W-1:0] rx_head;
    wire [`SMX_DATA_W-1:0] fifo_data;
    wire fifo_valid;
    wire fifo_pop;
    wire sw_pop;
    wire [`SMX_FIFO_AW:0] fifo_count;
    wire flow_irq_en = mode_ctl[`SMX_B_FLOWIE];
    wire cts_en = mode_ctl[`SMX_B_CLEAR_TO_SEND_FLOW_ENABLE];
    wire rts_en = mode_ctl[`SMX_B_REQUEST_TO_SEND_FLOW_ENABLE];
    wire txdma_en = mode_ctl[`SMX_B_TXDMA];
    wire rxdma_en = mode_ctl[`SMX_B_RXDMA];
    wire card_en = mode_ctl[`SMX_B_SMART_CARD_ENABLE];
    wire nack_en = mode_ctl[`SMX_B_NACK];
    wire hd_sel = mode_ctl[`SMX_B_HALF_DUPLEX_SELECT];
    wire ir_lp = mode_ctl[`SMX_B_INFRARED_LOW_POWER];
    wire ir_en = mode_ctl[`SMX_B_INFRARED_ENABLE];
    wire err_irq_en = mode_ctl[`SMX_B_EIE];
    wire [7:0] guard_interval = guard_pre[`SMX_GT_HI:`SMX_GT_LO];
    wire [7:0] clock_prescaler = guard_pre[`SMX_PSC_HI:`SMX_PSC_LO];
    wire [4:0] card_div = guard_pre[`SMX_PSC_CARD_HI:`SMX_PSC_LO];
    wire line_in;
    wire nack_active = (nack_cnt != 2'h0);

    // Address match used by both write and read decode
    // Full byte address compare, so the register map never aliases
    function hit;
        input [`SMX_ADDR_W-1:0] a;
        input [`SMX_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // Software writes to the two mode registers
    // Bits above each field are dropped, so reserved bits always read zero
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ctl <= `SMX_MODE_RST;
            guard_pre <= `SMX_GP_RST;
        end else if (reg_wr) begin
            if (hit(reg_addr, `SMX_OFF_MODE)) begin
                mode_ctl <= reg_wdata[`SMX_MODE_W-1:0];
            end
            if (hit(reg_addr, `SMX_OFF_GUARD)) begin
                guard_pre <= reg_wdata[`SMX_GP_W-1:0];
            end
        end
    end

    // Register read, data one cycle after the strobe; unmapped reads zero
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            if (hit(reg_addr, `SMX_OFF_MODE)) begin
                reg_rdata <= {21'h000000, mode_ctl};
            end else if (hit(reg_addr, `SMX_OFF_GUARD)) begin
                reg_rdata <= {16'h0000, guard_pre};
            end else if (hit(reg_addr, `SMX_OFF_RXDATA)) begin
                reg_rdata <= {23'h000000, rx_head};
            end else if (hit(reg_addr, `SMX_OFF_STATUS)) begin
                reg_rdata <= {23'h000000, guard_busy, nack_active, ~cts_n,
                              ~rx_char_ready, ~fifo_valid, fifo_count};
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // Receive buffer; a full buffer stalls the frame engine
    smx_fifo #(
        .W(`SMX_DATA_W),
        .D(`SMX_FIFO_DEPTH),
        .AW(`SMX_FIFO_AW)
    ) u_rx_fifo (
        .clk(mclk),
        .rst_n(arst_n),
        .in_data(rx_char),
        .in_valid(rx_char_valid),
        .in_ready(rx_char_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .count(fifo_count)
    );

    // Software read of the data register or a DMA ack drains one word
    assign sw_pop = reg_rd & hit(reg_addr, `SMX_OFF_RXDATA);
    assign fifo_pop = sw_pop | rx_dma_ack;

    // Head word as seen by the read process; it lands in reg_rdata on the
    // same edge that pops it, so the answer always matches the pop
    always @* begin
        rx_head = fifo_valid ? fifo_data : {`SMX_DATA_W{1'b0}};
    end

    // CTS gating of the next character start
    // Combinational so the engine sees the gate in the cycle it asks
    assign tx_char_go = tx_char_req & (~cts_en | ~cts_n);

    // Flow control, DMA requests and interrupt outputs
    // Interrupts are level mirrors of flags that are kept elsewhere
    // The DMA ack drops the request at once, so one ack drains one word
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rts_n <= 1'b0;
            tx_dma_req <= 1'b0;
            rx_dma_req <= 1'b0;
            flow_irq <= 1'b0;
            err_irq <= 1'b0;
        end else begin
            rts_n <= rts_en & ~rx_char_ready;
            tx_dma_req <= txdma_en & tx_buf_empty;
            rx_dma_req <= rxdma_en & fifo_valid & ~rx_dma_ack;
            flow_irq <= flow_irq_en & cts_change_flag;
            err_irq <= err_irq_en & rxdma_en &
                       (framing_error_flag | overrun_flag | noise_flag);
        end
    end

    // Low-power infrared clock: one tick every prescaler source cycles
    // Compare with >= so a smaller prescaler written mid-count takes hold
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lp_cnt <= 8'h00;
            lp_tick <= 1'b0;
        end else if (clock_prescaler == 8'h00) begin
            lp_cnt <= 8'h00;
            lp_tick <= 1'b0;
        end else if (lp_cnt >= clock_prescaler - 8'h01) begin
            lp_cnt <= 8'h00;
            lp_tick <= 1'b1;
        end else begin
            lp_cnt <= lp_cnt + 8'h01;
            lp_tick <= 1'b0;
        end
    end

    // Card clock toggles every low-5-bit prescaler cycles: period twice that
    // While disabled or held the clock keeps its level, so no runt edge
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            card_cnt <= 5'h00;
            card_clk <= 1'b0;
        end else if (!card_en || card_div == 5'h00) begin
            card_cnt <= 5'h00;
        end else if (card_cnt >= card_div - 5'h01) begin
            card_cnt <= 5'h00;
            card_clk <= ~card_clk;
        end else begin
            card_cnt <= card_cnt + 5'h01;
        end
    end

    // Infrared encoder: a zero bit becomes a narrow pulse at its start
    // Pulse width counts down on oversample or low-power ticks
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ir_width <= 2'h0;
            ir_out <= 1'b0;
        end else begin
            if (!ir_en) begin
                ir_width <= 2'h0;
            end else if (baud_tick && tx_active && !tx_bit) begin
                ir_width <= `SMX_IR_PULSE;
            end else if (ir_width != 2'h0 && (ir_lp ? lp_tick : os_tick)) begin
                ir_width <= ir_width - 2'h1;
            end
            ir_out <= ir_en & (ir_width != 2'h0);
        end
    end

    // Infrared decoder: a pulse seen in a bit period means zero
    // The seen flag stretches a short pulse over the rest of the bit
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ir_zero_seen <= 1'b0;
        end else if (baud_tick) begin
            ir_zero_seen <= 1'b0;
        end else if (ir_en && ir_in) begin
            ir_zero_seen <= 1'b1;
        end
    end

    // Half duplex takes reception from the shared transmit line
    assign line_in = hd_sel ? txd_i : rxd_i;
    assign rx_bit = ir_en ? ~(ir_in | ir_zero_seen) : line_in;

    // Smart card NACK: line held low for two baud ticks after parity error
    // A second parity error restarts the window rather than extending it
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            nack_cnt <= 2'h0;
        end else if (card_en && nack_en && rx_parity_err) begin
            nack_cnt <= `SMX_NACK_BITS;
        end else if (nack_active && baud_tick) begin
            nack_cnt <= nack_cnt - 2'h1;
        end
    end

    // Line driver; in half duplex the pin is released while idle
    // Infrared mode idles the plain line high; pulses leave on ir_out
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            txd_o <= 1'b1;
            txd_oe <= 1'b0;
        end else begin
            txd_o <= nack_active ? 1'b0 : (ir_en ? 1'b1 : tx_bit);
            txd_oe <= hd_sel ? (tx_active | nack_active) : 1'b1;
        end
    end

    // Transmit complete, delayed by the guard interval in smart card mode
    // A new character end restarts the guard count: the last end wins
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            guard_cnt <= 8'h00;
            guard_busy <= 1'b0;
            tx_complete_set <= 1'b0;
        end else begin
            tx_complete_set <= 1'b0;
            if (tx_char_end) begin
                if (card_en && guard_interval != 8'h00) begin
                    guard_cnt <= guard_interval;
                    guard_busy <= 1'b1;
                end else begin
                    tx_complete_set <= 1'b1;
                end
            end else if (guard_busy && baud_tick) begin
                if (guard_cnt == 8'h01) begin
                    guard_busy <= 1'b0;
                    tx_complete_set <= 1'b1;
                end
                guard_cnt <= guard_cnt - 8'h01;
            end
        end
    end
endmodule // smx_mode_ext

/* smx_mode_ext_monitor.sv */
// Port-level assertions for the serial mode extension block
`include "smx_regs.vh"
module smx_mode_ext_monitor (
    input wire mclk,
    input wire arst_n,
    input wire [`SMX_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire tx_char_req,
    input wire tx_char_go,
    input wire tx_char_end,
    input wire tx_complete_set,
    input wire tx_buf_empty,
    input wire tx_dma_req,
    input wire rx_dma_req,
    input wire rx_parity_err,
    input wire framing_error_flag,
    input wire overrun_flag,
    input wire noise_flag,
    input wire cts_change_flag,
    input wire flow_irq,
    input wire err_irq,
    input wire cts_n,
    input wire rts_n,
    input wire txd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    reg [10:0] m;
    // Shadow of the mode register, updated on the same edge as the block
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            m <= `SMX_MODE_RST;
        end else if (reg_wr && reg_addr == `SMX_OFF_MODE) begin
            m <= reg_wdata[10:0];
        end
    end
    a_cts_gate: assert property (
        tx_char_go == (tx_char_req && (!m[9] || !cts_n))) else $error("go");
    a_flow_irq: assert property (
        flow_irq == ($past(m[10]) && $past(cts_change_flag)))
        else $error("flow irq");
    a_err_irq: assert property (
        err_irq == ($past(m[0]) && $past(m[6]) && ($past(framing_error_flag)
        || $past(overrun_flag) || $past(noise_flag)))) else $error("err irq");
    a_tx_dma: assert property (
        tx_dma_req == ($past(m[7]) && $past(tx_buf_empty))) else $error("txd");
    a_rx_dma_gate: assert property (
        rx_dma_req |-> $past(m[6])) else $error("rx dma");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata idle");
    a_mode_read: assert property (
        reg_rd && reg_addr == `SMX_OFF_MODE |=> reg_rdata == {21'h0, $past(m)})
        else $error("mode read");
    a_done_plain: assert property (
        tx_char_end && !m[5] |=> tx_complete_set) else $error("complete");
    a_rts_off: assert property (
        !m[8] && !$past(m[8]) |-> !rts_n) else $error("rts");
    a_nack_drive: assert property (
        rx_parity_err && m[5] && m[4] |-> ##2 !txd_o) else $error("nack");
endmodule // smx_mode_ext_monitor

bind smx_mode_ext smx_mode_ext_monitor u_smx_mode_ext_monitor (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_char_req(tx_char_req),
    .tx_char_go(tx_char_go), .tx_char_end(tx_char_end),
    .tx_complete_set(tx_complete_set), .tx_buf_empty(tx_buf_empty),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
    .rx_parity_err(rx_parity_err), .framing_error_flag(framing_error_flag),
    .overrun_flag(overrun_flag), .noise_flag(noise_flag),
    .cts_change_flag(cts_change_flag), .flow_irq(flow_irq),
    .err_irq(err_irq), .cts_n(cts_n), .rts_n(rts_n), .txd_o(txd_o));

/* smx_peer_model.sv */
// Line-side peer: slow clear-to-send and echo of the transmit lines
module smx_peer_model (
    input wire mclk,
    input wire hold,
    input wire txd_o,
    input wire ir_out,
    output logic cts_n,
    output logic rxd_i,
    output logic ir_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hold_q = 1'b0;
    // Idle levels before the first edge
    initial begin
        cts_n = 1'b0;
        rxd_i = 1'b1;
        ir_in = 1'b0;
    end
    // CTS follows hold two cycles late, like a sluggish peer
    always @(posedge mclk) begin
        hold_q <= hold;
        cts_n <= hold_q;
        rxd_i <= txd_o;
        ir_in <= ir_out;
    end
endmodule // smx_peer_model

/* smx_regs.vh */
// Register offsets, field positions, reset values and widths of the serial mode block
`ifndef SMX_REGS_VH
`define SMX_REGS_VH

`define SMX_ADDR_W 8
`define SMX_OFF_MODE 8'h00
`define SMX_OFF_GUARD 8'h04
`define SMX_OFF_RXDATA 8'h08
`define SMX_OFF_STATUS 8'h0C

`define SMX_MODE_W 11
`define SMX_MODE_RST 11'h000
`define SMX_GP_W 16
`define SMX_GP_RST 16'h0000

`define SMX_B_FLOWIE 10
`define SMX_B_CLEAR_TO_SEND_FLOW_ENABLE 9
`define SMX_B_REQUEST_TO_SEND_FLOW_ENABLE 8
`define SMX_B_TXDMA 7
`define SMX_B_RXDMA 6
`define SMX_B_SMART_CARD_ENABLE 5
`define SMX_B_NACK 4
`define SMX_B_HALF_DUPLEX_SELECT 3
`define SMX_B_INFRARED_LOW_POWER 2
`define SMX_B_INFRARED_ENABLE 1
`define SMX_B_EIE 0

`define SMX_GT_HI 15
`define SMX_GT_LO 8
`define SMX_PSC_HI 7
`define SMX_PSC_LO 0
`define SMX_PSC_CARD_HI 4

`define SMX_DATA_W 9
`define SMX_FIFO_DEPTH 8
`define SMX_FIFO_AW 3
`define SMX_CNT_W 4

`define SMX_IR_PULSE 2'h3
`define SMX_NACK_BITS 2'h2
`define SMX_ST_EMPTY 4
`define SMX_ST_FULL 5
`define SMX_ST_CTS 6
`define SMX_ST_NACK 7
`define SMX_ST_GUARD 8

`endif

/* tb_top.sv */
// Self-checking bench for the serial mode extension block
`include "smx_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic rd_v = 1'b0, hold = 1'b0, baud_tick = 1'b0, os_tick = 1'b0;
    logic tx_bit = 1'b1, tx_buf_empty = 1'b0, tx_char_req = 1'b0;
    logic tx_active = 1'b0;
    logic tx_char_end = 1'b0, rx_char_valid = 1'b0, rx_parity_err = 1'b0;
    logic rx_dma_ack = 1'b0, framing_error_flag = 1'b0, overrun_flag = 1'b0;
    logic noise_flag = 1'b0, cts_change_flag = 1'b0, c;
    logic [1:0] bc = 2'h0;
    logic [8:0] rx_char = 9'h000;
    logic [8:0] dq[8];
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, r;
    logic [31:0] exp_q[$];
    wire [31:0] reg_rdata;
    wire tx_char_go, tx_complete_set, tx_dma_req, rx_bit, rx_char_ready;
    wire rx_dma_req, flow_irq, err_irq, cts_n, rts_n, txd_o, txd_oe;
    wire rxd_i, ir_in, ir_out, card_clk, txd_i;
    int num_errors = 0, compares = 0, seed, i, k, n;
    always #4 mclk = ~mclk;
    // Shared line is pulled high whenever the block lets go of it
    assign txd_i = txd_oe ? txd_o : 1'b1;
    smx_mode_ext u_smx_mode_ext (.mclk(mclk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .baud_tick(baud_tick),
        .os_tick(os_tick), .tx_bit(tx_bit), .tx_active(tx_active),
        .tx_buf_empty(tx_buf_empty), .tx_char_req(tx_char_req),
        .tx_char_go(tx_char_go), .tx_char_end(tx_char_end),
        .tx_complete_set(tx_complete_set), .tx_dma_req(tx_dma_req),
        .rx_bit(rx_bit), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
        .rx_char_ready(rx_char_ready), .rx_parity_err(rx_parity_err),
        .framing_error_flag(framing_error_flag), .overrun_flag(overrun_flag),
        .noise_flag(noise_flag), .cts_change_flag(cts_change_flag),
        .rx_dma_req(rx_dma_req), .rx_dma_ack(rx_dma_ack), .flow_irq(flow_irq),
        .err_irq(err_irq), .cts_n(cts_n), .rts_n(rts_n), .txd_i(txd_i),
        .txd_o(txd_o), .txd_oe(txd_oe), .rxd_i(rxd_i), .ir_in(ir_in),
        .ir_out(ir_out), .card_clk(card_clk));
    smx_peer_model u_smx_peer_model (.mclk(mclk), .hold(hold),
        .txd_o(txd_o), .ir_out(ir_out), .cts_n(cts_n), .rxd_i(rxd_i),
        .ir_in(ir_in));
    // Baud tick every fourth cycle, oversample tick every second;
    // the transmit bit flips at each baud tick so zeros reach the encoder
    always @(posedge mclk) begin
        bc <= bc + 2'h1;
        baud_tick <= (bc == 2'h3);
        os_tick <= bc[0];
        tx_bit <= (bc == 2'h3) ? ~tx_bit : tx_bit;
        rd_v <= reg_rd;
    end
    task automatic finish_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t read %h want %h", $time, g, e);
        end
    endtask
    task automatic chk(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t bit %b want %b", $time, g, e);
        end
    endtask
    // Read data lands in the cycle after the strobe; oldest note first
    always @(negedge mclk) begin
        if (rd_v) begin
            cmp(reg_rdata, exp_q.pop_front());
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask
    task automatic at(input int t);
        repeat (t) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic push(input logic [8:0] d);
        @(posedge mclk);
        rx_char_valid <= 1'b1;
        rx_char <= d;
        @(posedge mclk);
        rx_char_valid <= 1'b0;
    endtask
    // Ends a character so that no baud tick shares its cycle
    task automatic sc(input int e);
        int j, t;
        t = 0;
        @(negedge mclk);
        for (j = 0; j < 4 && bc !== 2'h2; j++) @(negedge mclk);
        @(posedge mclk);
        tx_char_end <= 1'b1;
        @(posedge mclk);
        tx_char_end <= 1'b0;
        for (j = 0; j < 64; j++) begin
            @(negedge mclk);
            if (tx_complete_set === 1'b1) break;
            t += baud_tick;
        end
        chk(j < 64 && t == e, 1'b1);
    endtask
    initial begin
        #400000;
        num_errors++;
        finish_test;
    end
    initial begin
        seed = 32'h41a5;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        at(1);
        chk(txd_oe, 1'b1);
        chk(rx_bit, rxd_i);
        rd(`SMX_OFF_MODE, 32'h0);
        rd(`SMX_OFF_GUARD, 32'h0);
        rd(8'h10, 32'h0);
        for (i = 0; i < 11; i++) begin
            wr(`SMX_OFF_MODE, 32'h1 << i);
            rd(`SMX_OFF_MODE, 32'h1 << i);
        end
        wr(`SMX_OFF_MODE, 32'hFFFFFFFF);
        rd(`SMX_OFF_MODE, 32'h7FF);
        r = $random(seed);
        wr(`SMX_OFF_GUARD, r);
        rd(`SMX_OFF_GUARD, r & 32'hFFFF);
        wr(`SMX_OFF_MODE, 32'h8);
        at(2);
        chk(txd_oe, 1'b0);
        chk(rx_bit, txd_i);
        chk(rts_n, 1'b0);
        wr(`SMX_OFF_MODE, 32'h200);
        hold <= 1'b1;
        tx_char_req <= 1'b1;
        at(4);
        chk(tx_char_go, 1'b0);
        hold <= 1'b0;
        at(4);
        chk(tx_char_go, 1'b1);
        wr(`SMX_OFF_MODE, 32'h441);
        cts_change_flag <= 1'b1;
        at(2);
        chk(flow_irq, 1'b1);
        for (i = 0; i < 3; i++) begin
            @(posedge mclk);
            cts_change_flag <= 1'b0;
            {framing_error_flag, overrun_flag, noise_flag} <= 3'h1 << i;
            at(2);
            chk(err_irq, 1'b1);
            chk(flow_irq, 1'b0);
        end
        wr(`SMX_OFF_MODE, 32'h81);
        tx_buf_empty <= 1'b1;
        at(2);
        chk(err_irq, 1'b0);
        chk(tx_dma_req, 1'b1);
        @(posedge mclk);
        {framing_error_flag, overrun_flag, noise_flag} <= 3'h0;
        tx_buf_empty <= 1'b0;
        wr(`SMX_OFF_MODE, 32'h100);
        for (i = 0; i < 8; i++) begin
            dq[i] = $random(seed);
            push(dq[i]);
        end
        at(2);
        chk(rx_char_ready, 1'b0);
        chk(rts_n, 1'b1);
        rd(`SMX_OFF_STATUS, 32'h68);
        for (i = 0; i < 8; i++) rd(`SMX_OFF_RXDATA, {23'h0, dq[i]});
        rd(`SMX_OFF_RXDATA, 32'h0);
        wr(`SMX_OFF_MODE, 32'h40);
        push(9'h1A5);
        at(2);
        chk(rx_dma_req, 1'b1);
        @(posedge mclk);
        rx_dma_ack <= 1'b1;
        @(posedge mclk);
        rx_dma_ack <= 1'b0;
        at(2);
        chk(rx_dma_req, 1'b0);
        rd(`SMX_OFF_STATUS, 32'h50);
        wr(`SMX_OFF_GUARD, 32'h0223);
        wr(`SMX_OFF_MODE, 32'h0);
        sc(0);
        wr(`SMX_OFF_MODE, 32'h20);
        sc(2);
        c = card_clk;
        for (k = 0; k < 20 && card_clk === c; k++) @(negedge mclk);
        c = card_clk;
        for (n = 0; n < 20 && card_clk === c; n++) @(negedge mclk);
        chk(n == 3, 1'b1);
        wr(`SMX_OFF_GUARD, 32'h0220);
        at(2);
        c = card_clk;
        at(12);
        chk(card_clk, c);
        wr(`SMX_OFF_MODE, 32'h30);
        rx_parity_err <= 1'b1;
        @(posedge mclk);
        rx_parity_err <= 1'b0;
        at(1);
        chk(txd_o, 1'b0);
        wr(`SMX_OFF_GUARD, 32'h0001);
        tx_active <= 1'b1;
        for (i = 0; i < 2; i++) begin
            wr(`SMX_OFF_MODE, i ? 32'h6 : 32'h2);
            c = 1'b0;
            for (k = 0; k < 64; k++) begin
                @(negedge mclk);
                c = c | (ir_out === 1'b1);
            end
            chk(c, 1'b1);
            // Pulse spans three ticks: oversample every 2, prescaled every 1
            for (k = 0; k < 64 && ir_out !== 1'b0; k++) @(negedge mclk);
            for (k = 0; k < 64 && ir_out !== 1'b1; k++) @(negedge mclk);
            for (n = 0; n < 64 && ir_out === 1'b1; n++) @(negedge mclk);
            chk(n == (i ? 3 : 6), 1'b1);
        end
        finish_test;
    end
endmodule // tb_top
